// ==== rtl/csd_top.sv ====
// Charge status bar display, alarm flags and protection switch drive.
`timescale 1ns/1ps
`include "csd_params.svh"
// Operation
// - Request fall lights display, starts 4 s
// - Timer expiry turns display off always
// - Relight needs release then later fall
// - Request level accepted after 250 ms
// - Reference select picks full or design
// - Option selects four or five segments
// - Fifth output marks 100 % in four-segment
// - Five-segment thresholds at 20 % steps
// - Four-segment thresholds at 25 % steps
// - End-voltage-zero blanks every segment
// - Display blanked during converter calibration
// - Lit segments blink below capacity alarm
// - Cell overvoltage from voltage, cells, temperature
// - Overvoltage pulls charge switch unless discharging
// - Safety overtemperature pulls charge switch always
// - Option bit six: only safety temperature
// - Cell undervoltage when any cell low
// - Undervoltage pulls discharge switch when discharging
// - Status nibble holds flags and switches
// - Overcurrent zeroes request, sets terminate alarm
// - Max temperature sets flags with hysteresis
// - Cell undervoltage sets terminate-discharge alarm
// - Fast-charge termination sets maintenance, flags
// - Cell limits from configuration nibbles
// - Safety threshold, options from configuration bytes
module csd_top #(
	parameter logic [31:0] DISPLAY_REQUEST_N_CYCLES = `CSD_DISPLAY_REQUEST_N_CYC,
	parameter logic [31:0] DEB_CYCLES = `CSD_DEB_CYC,
	parameter logic [31:0] BLINK_CYCLES = `CSD_BLINK_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	// Pushbutton pin, active low, asynchronous.
	input wire logic display_request_n,
	// High selects design capacity as the full-scale value.
	input wire logic display_reference_select,
	// High selects the five-segment display.
	input wire logic five_segment_mode,
	input wire logic [15:0] remaining_cap,
	input wire logic [15:0] full_charge_cap,
	input wire logic [15:0] design_cap,
	input wire logic [15:0] low_capacity_level,
	input wire logic end_voltage_zero_flag,
	input wire logic charge_counter_converter_cal,
	input wire logic discharging_status,
	// Pack voltage and the four cell voltages in millivolts.
	input wire logic [15:0] pack_voltage,
	input wire logic [3:0][15:0] cell_voltage,
	input wire logic [15:0] charging_voltage,
	input wire logic [15:0] overvoltage_margin,
	// Signed current in mA, charge positive.
	input wire logic [15:0] measured_current,
	input wire logic [15:0] requested_charge_current,
	input wire logic [15:0] overcurrent_margin,
	input wire logic [15:0] maintenance_current,
	// Temperatures in 0.1 K.
	input wire logic [15:0] temperature,
	input wire logic [15:0] max_charge_temp,
	// Configuration bytes: safety threshold, options, cell limits.
	input wire logic [7:0] safety_temp_byte,
	input wire logic [7:0] extra_options,
	input wire logic [7:0] cell_limit_byte,
	// Fast-charge termination event and its standing condition.
	input wire logic fast_charge_term,
	input wire logic term_condition,
	// State of charge is below the fully-charged clear level.
	input wire logic soc_below_fc_clear,
	output logic [4:0] display_segment,
	output logic charge_switch_ctl,
	output logic discharge_switch_ctl,
	output logic [3:0] pack_safety_status,
	output logic [15:0] charge_current_request,
	output logic terminate_charge_alarm,
	output logic over_temperature_alarm,
	output logic terminate_discharge_alarm,
	output logic fully_charged_flag,
	output logic low_capacity_alarm
);
	// ****************************************
	// Declarations
	// ****************************************
	// Registered state and its next value.
	csd_pkg::csd_top_t r;
	csd_pkg::csd_top_t next_r;
	// Filtered request level.
	logic req_level;
	// Full-scale reference for the bar graph.
	logic [15:0] ref_cap;
	// Segment thresholds passed.
	logic [3:0] passed;
	// Lit pattern before blanking.
	logic [4:0] pattern;
	// Decoded thresholds.
	logic [15:0] uv_limit;
	logic [15:0] ov_limit;
	logic [15:0] sot_limit;
	// Live conditions.
	logic cell_hi;
	logic cell_lo;
	logic ov_hit;
	logic oc_hit;
	logic sot_ge;
	logic sot_gt;
	logic [16:0] ov_sum;
	logic [16:0] oc_sum;

	// ****************************************
	// Request input and level compare
	// ****************************************
	// two-stage synchroniser
	csd_debounce #(
		.STABLE_CYCLES(DEB_CYCLES)
	) u_debounce (
		.mclk(mclk),
		.srst(srst),
		.pin_n(display_request_n),
		.level(req_level)
	);

	assign ref_cap = display_reference_select ? design_cap : full_charge_cap;

	csd_soc_levels u_levels (
		.remaining_cap(remaining_cap),
		.ref_cap(ref_cap),
		.five_seg(five_segment_mode),
		.passed(passed)
	);

	assign pattern = {passed, 1'b1};

	// ****************************************
	// Thresholds from configuration
	// ****************************************
	// undervoltage upper, overvoltage lower
	assign uv_limit = `CSD_UV_BASE + 16'(cell_limit_byte[7:4]) * `CSD_UV_STEP;
	assign ov_limit = `CSD_OV_BASE + 16'(cell_limit_byte[3:0]) * `CSD_OV_STEP;
	assign sot_limit = `CSD_SOT_BASE + 16'(safety_temp_byte) * `CSD_SOT_SCALE;

	// Any cell beyond either limit.
	always_comb begin
		cell_hi = 1'b0;
		cell_lo = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (cell_voltage[i] >= ov_limit) begin
				cell_hi = 1'b1;
			end
			if (cell_voltage[i] < uv_limit) begin
				cell_lo = 1'b1;
			end
		end
	end

	// Sums are widened so a large margin cannot wrap.
	assign ov_sum = 17'(charging_voltage) + 17'(overvoltage_margin);
	assign oc_sum = 17'(requested_charge_current) + 17'(overcurrent_margin);
	assign ov_hit = (17'(pack_voltage) >= ov_sum) | cell_hi;
	assign oc_hit = ~measured_current[15] & (17'(measured_current) >= oc_sum);
	assign sot_ge = temperature >= sot_limit;
	assign sot_gt = temperature > sot_limit;

	// ****************************************
	// Next-state logic
	// ****************************************
	// Computes every register's next value from the current state.
	always_comb begin
		next_r = r;
		next_r.last_level = req_level;

		// Display sequencer.
		case (r.state)
			csd_pkg::CSD_IDLE: begin
				if (r.last_level & ~req_level) begin
					next_r.state = csd_pkg::CSD_LIT;
					next_r.display_request_n_count = 32'h0;
				end
			end
			csd_pkg::CSD_LIT: begin
				if (r.display_request_n_count >= DISPLAY_REQUEST_N_CYCLES - 32'h1) begin
					next_r.display_request_n_count = 32'h0;
					next_r.state = req_level ? csd_pkg::CSD_IDLE : csd_pkg::CSD_HOLD;
				end else begin
					next_r.display_request_n_count = r.display_request_n_count + 32'h1;
				end
			end
			csd_pkg::CSD_HOLD: begin
				if (req_level) begin
					next_r.state = csd_pkg::CSD_IDLE;
				end
			end
			default: begin
				next_r.state = csd_pkg::CSD_IDLE;
			end
		endcase

		// blink timer runs only while lit
		if (r.state != csd_pkg::CSD_LIT) begin
			next_r.blink_count = 32'h0;
			next_r.blink_phase = 1'b0;
		end else if (r.blink_count >= BLINK_CYCLES - 32'h1) begin
			next_r.blink_count = 32'h0;
			next_r.blink_phase = ~r.blink_phase;
		end else begin
			next_r.blink_count = r.blink_count + 32'h1;
		end

		// Low capacity flag.
		next_r.lowcap = remaining_cap < low_capacity_level;

		// Segment outputs.
		next_r.seg = 5'h00;
		if ((r.state == csd_pkg::CSD_LIT) & ~end_voltage_zero_flag & ~charge_counter_converter_cal) begin
			if (!(r.lowcap & r.blink_phase)) begin
				next_r.seg = pattern;
			end
		end

		if (temperature >= max_charge_temp) begin
			next_r.ot = 1'b1;
		end else if ((temperature <= max_charge_temp - `CSD_TEMP_HYST) | (temperature <= `CSD_TEMP_43C)) begin
			next_r.ot = 1'b0;
		end

		next_r.cov = ov_hit | next_r.ot;
		next_r.cuv = cell_lo;
		next_r.oc = oc_hit;

		// Overvoltage terminate alarm holds until discharge; set wins.
		if (ov_hit) begin
			next_r.ov_tca = 1'b1;
		end else if (discharging_status) begin
			next_r.ov_tca = 1'b0;
		end

		if (fast_charge_term) begin
			next_r.term_tca = 1'b1;
		end else if (discharging_status | ~term_condition) begin
			next_r.term_tca = 1'b0;
		end
		if (fast_charge_term) begin
			next_r.fc = 1'b1;
		end else if (soc_below_fc_clear) begin
			next_r.fc = 1'b0;
		end

		// Charge current request.
		// overcurrent requests zero
		if (oc_hit | next_r.ot | ov_hit) begin
			next_r.cc_req = 16'h0000;
		end else if (next_r.fc) begin
			next_r.cc_req = maintenance_current;
		end else begin
			next_r.cc_req = requested_charge_current;
		end

		// Charge switch, active low.
		if (extra_options[`CSD_OPT_SOT_ONLY]) begin
			next_r.cfc = ~sot_gt;
		end else begin
			next_r.cfc = ~(sot_ge | (next_r.cov & ~discharging_status));
		end
		next_r.dfc = ~(next_r.cuv & discharging_status);
	end

	// ****************************************
	// State register
	// ****************************************
	// reset turns segments off
	always_ff @(posedge mclk) begin
		if (srst) begin
			r <= '{
				state: csd_pkg::CSD_IDLE,
				last_level: 1'b1,
				display_request_n_count: 32'h0,
				blink_count: 32'h0,
				blink_phase: 1'b0,
				seg: 5'h00,
				ot: 1'b0,
				ov_tca: 1'b0,
				term_tca: 1'b0,
				fc: 1'b0,
				oc: 1'b0,
				cov: 1'b0,
				cuv: 1'b0,
				cfc: 1'b1,
				dfc: 1'b1,
				lowcap: 1'b0,
				cc_req: 16'h0000
			};
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign display_segment = r.seg;
	assign charge_switch_ctl = r.cfc;
	assign discharge_switch_ctl = r.dfc;
	assign pack_safety_status[`CSD_ST_COV] = r.cov;
	assign pack_safety_status[`CSD_ST_CUV] = r.cuv;
	assign pack_safety_status[`CSD_ST_CFC] = r.cfc;
	assign pack_safety_status[`CSD_ST_DFC] = r.dfc;
	assign charge_current_request = r.cc_req;
	assign terminate_charge_alarm = r.oc | r.ot | r.ov_tca | r.term_tca;
	assign over_temperature_alarm = r.ot;
	assign terminate_discharge_alarm = r.cuv;
	assign fully_charged_flag = r.fc;
	assign low_capacity_alarm = r.lowcap;
endmodule : csd_top

// ==== rtl/csd_params.svh ====
// Timing counts, thresholds, encodings and status bit positions for the charge status display block.
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH
// System clock rate in hertz (50 ns period).
`define CSD_CLK_HZ 20000000
// Display on-time in milliseconds and in clock cycles.
`define CSD_DISPLAY_REQUEST_N_MS 4000
`define CSD_DISPLAY_REQUEST_N_CYC (`CSD_DISPLAY_REQUEST_N_MS * (`CSD_CLK_HZ / 1000))
// Least stable time of the request input in milliseconds and cycles.
`define CSD_DEB_MS 250
`define CSD_DEB_CYC (`CSD_DEB_MS * (`CSD_CLK_HZ / 1000))
// Half period of the low-capacity blink in milliseconds and cycles.
`define CSD_BLINK_MS 500
`define CSD_BLINK_CYC (`CSD_BLINK_MS * (`CSD_CLK_HZ / 1000))
// Segment steps and full scale in percent.
`define CSD_STEP5 20
`define CSD_STEP4 25
`define CSD_FULL_PCT 24'd100
// Temperatures are in 0.1 K; 43 C and the 5 C release margin.
`define CSD_TEMP_43C 16'd3161
`define CSD_TEMP_HYST 16'd50
// Safety threshold byte: 0.1 K = base + byte * scale.
`define CSD_SOT_BASE 16'd2731
`define CSD_SOT_SCALE 16'd10
// Cell limit nibbles: millivolts = base + nibble * step.
`define CSD_UV_BASE 16'd2000
`define CSD_UV_STEP 16'd100
`define CSD_OV_BASE 16'd3900
`define CSD_OV_STEP 16'd50
// Option bit that restricts the charge switch to the safety limit.
`define CSD_OPT_SOT_ONLY 6
// Pack safety status nibble bit positions.
`define CSD_ST_COV 0
`define CSD_ST_CUV 1
`define CSD_ST_CFC 2
`define CSD_ST_DFC 3
`endif

// ==== rtl/csd_pkg.sv ====
// Types shared by the charge status display modules.
package csd_pkg;
	// Display sequencer states, one-hot.
	typedef enum logic [2:0] {
		CSD_IDLE = 3'b001,
		CSD_LIT = 3'b010,
		CSD_HOLD = 3'b100
	} csd_display_request_n_state_t;
	// Request input filter state.
	typedef struct packed {
		logic [1:0] sync;
		logic level;
		logic [31:0] count;
	} csd_deb_t;
	// Whole state of the top module.
	typedef struct packed {
		csd_display_request_n_state_t state;
		logic last_level;
		logic [31:0] display_request_n_count;
		logic [31:0] blink_count;
		logic blink_phase;
		logic [4:0] seg;
		logic ot;
		logic ov_tca;
		logic term_tca;
		logic fc;
		logic oc;
		logic cov;
		logic cuv;
		logic cfc;
		logic dfc;
		logic lowcap;
		logic [15:0] cc_req;
	} csd_top_t;
endpackage : csd_pkg

// ==== rtl/csd_debounce.sv ====
// Synchroniser and stable-level filter for the display request pin.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_debounce #(
	parameter logic [31:0] STABLE_CYCLES = `CSD_DEB_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic pin_n,
	output logic level
);
	// Registered state and its next value.
	csd_pkg::csd_deb_t r;
	csd_pkg::csd_deb_t next_r;

	// The second sync stage alone feeds the filter; a new level is
	// accepted only after it has held for the full stable time.
	always_comb begin
		next_r = r;
		next_r.sync = {r.sync[0], pin_n};
		if (r.sync[1] == r.level) begin
			next_r.count = 32'h0;
		end else if (r.count >= STABLE_CYCLES - 32'h1) begin
			next_r.level = r.sync[1];
			next_r.count = 32'h0;
		end else begin
			next_r.count = r.count + 32'h1;
		end
	end

	// Reset to the idle (released) level.
	always_ff @(posedge mclk) begin
		if (srst) begin
			r <= '{sync: 2'h3, level: 1'b1, count: 32'h0};
		end else begin
			r <= next_r;
		end
	end

	assign level = r.level;
endmodule : csd_debounce

// ==== rtl/csd_soc_levels.sv ====
// Compares remaining capacity against the segment thresholds.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_soc_levels (
	input wire logic [15:0] remaining_cap,
	input wire logic [15:0] ref_cap,
	input wire logic five_seg,
	output logic [3:0] passed
);
	// Remaining capacity times 100, compared against the reference times each step percent.
	logic [23:0] rem_x100;
	assign rem_x100 = 24'(remaining_cap) * `CSD_FULL_PCT;

	// Step k is passed at (k+1) x 20 % or (k+1) x 25 %; the last
	// 25 % step is the 100 % mark used by the fifth output.
	for (genvar k = 0; k < 4; k++) begin : g_step
		logic [23:0] pct;
		assign pct = five_seg ? 24'(`CSD_STEP5 * (k + 1)) : 24'(`CSD_STEP4 * (k + 1));
		assign passed[k] = rem_x100 >= 24'(ref_cap) * pct;
	end
endmodule : csd_soc_levels

// ==== tb/csd_sva.sv ====
// Port-level assertions for the charge status display block.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_top_chk (
	input wire logic mclk,
	input wire logic srst,
	input wire logic end_voltage_zero_flag,
	input wire logic charge_counter_converter_cal,
	input wire logic discharging_status,
	input wire logic [3:0][15:0] cell_voltage,
	input wire logic [15:0] temperature,
	input wire logic [15:0] max_charge_temp,
	input wire logic [7:0] safety_temp_byte,
	input wire logic [7:0] extra_options,
	input wire logic [7:0] cell_limit_byte,
	input wire logic [4:0] display_segment,
	input wire logic charge_switch_ctl,
	input wire logic discharge_switch_ctl,
	input wire logic [3:0] pack_safety_status,
	input wire logic [15:0] charge_current_request,
	input wire logic terminate_charge_alarm,
	input wire logic over_temperature_alarm,
	input wire logic terminate_discharge_alarm
);
	// Undervoltage limit, safety temperature and the any-cell-low flag.
	logic [15:0] uv_lim;
	logic [15:0] sot_lim;
	logic uv_any;
	always_comb begin
		uv_lim = `CSD_UV_BASE + 16'(cell_limit_byte[7:4]) * `CSD_UV_STEP;
		sot_lim = `CSD_SOT_BASE + 16'(safety_temp_byte) * `CSD_SOT_SCALE;
		uv_any = 1'b0;
		for (int i = 0; i < 4; i++) uv_any = uv_any | (cell_voltage[i] < uv_lim);
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_reset_dark: assert property (disable iff (1'b0)
		srst |=> display_segment == 5'h00 && charge_switch_ctl && discharge_switch_ctl)
		else $error("outputs not idle after reset");
	a_edv_blank: assert property (end_voltage_zero_flag |=> display_segment == 5'h00)
		else $error("segments lit at end voltage");
	a_cal_blank: assert property (charge_counter_converter_cal |=> display_segment == 5'h00)
		else $error("segments lit during calibration");
	a_bar_shape: assert property (display_segment != 5'h00 |->
		display_segment[0] && ((display_segment + 5'h01) & display_segment) == 5'h00)
		else $error("segment pattern not a bar");
	a_uv_set: assert property (uv_any |=> pack_safety_status[1] && terminate_discharge_alarm)
		else $error("undervoltage flags not set");
	a_uv_clear: assert property (!uv_any |=> !pack_safety_status[1])
		else $error("undervoltage flag stuck");
	a_dfc_pull: assert property (uv_any && discharging_status |=> !discharge_switch_ctl)
		else $error("discharge switch not pulled");
	a_pin_mirror: assert property (pack_safety_status[3:2] == {discharge_switch_ctl, charge_switch_ctl})
		else $error("status nibble differs from switches");
	a_sot_cfc: assert property (temperature > sot_lim |=> !charge_switch_ctl)
		else $error("charge switch not pulled at safety limit");
	a_opt6_only: assert property (extra_options[6] && temperature <= sot_lim |=> charge_switch_ctl)
		else $error("charge switch pulled below safety limit");
	a_ot_flags: assert property (temperature >= max_charge_temp |=> over_temperature_alarm &&
		terminate_charge_alarm && pack_safety_status[0] && charge_current_request == 16'h0000)
		else $error("overtemperature response missing");
endmodule : csd_top_chk
bind csd_top csd_top_chk i_csd_top_chk (.mclk, .srst, .end_voltage_zero_flag, .charge_counter_converter_cal,
	.discharging_status, .cell_voltage, .temperature, .max_charge_temp, .safety_temp_byte, .extra_options,
	.cell_limit_byte, .display_segment, .charge_switch_ctl, .discharge_switch_ctl, .pack_safety_status,
	.charge_current_request, .terminate_charge_alarm, .over_temperature_alarm, .terminate_discharge_alarm);

// ==== tb/csd_button.sv ====
// Pushbutton model with pull-up and commanded contact bounce.
`timescale 1ns/1ps
module csd_button (
	input wire logic mclk,
	input wire logic press,
	input wire logic bounce,
	output logic display_request_n
);
	// Toggle that makes the contact chatter when bounce is commanded.
	logic chatter = 1'b0;
	always @(posedge mclk) begin
		chatter <= ~chatter;
	end
	// The pull-up holds the pin high while the button is open.
	assign display_request_n = bounce ? chatter : ~press;
endmodule : csd_button

// ==== tb/csd_top_bench.sv ====
// Self-checking bench for the charge status display block.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_top_bench;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic press = 1'b0;
	logic bounce = 1'b0;
	logic display_request_n;
	logic display_reference_select = 1'b0;
	logic five_segment_mode = 1'b0;
	logic [15:0] remaining_cap = 16'd50;
	logic [15:0] full_charge_cap = 16'd100;
	logic [15:0] design_cap = 16'd200;
	logic [15:0] low_capacity_level = 16'd0;
	logic end_voltage_zero_flag = 1'b0;
	logic charge_counter_converter_cal = 1'b0;
	logic discharging_status = 1'b0;
	logic [15:0] pack_voltage = 16'd0;
	logic [3:0][15:0] cell_voltage = {4{16'd3700}};
	logic [15:0] charging_voltage = 16'd8000;
	logic [15:0] overvoltage_margin = 16'd100;
	logic [15:0] measured_current = 16'd0;
	logic [15:0] requested_charge_current = 16'd1000;
	logic [15:0] overcurrent_margin = 16'd100;
	logic [15:0] maintenance_current = 16'd50;
	logic [15:0] temperature = 16'd2981;
	logic [15:0] max_charge_temp = 16'd3231;
	logic [7:0] safety_temp_byte = 8'd60;
	logic [7:0] extra_options = 8'h00;
	logic [7:0] cell_limit_byte = 8'h00;
	logic fast_charge_term = 1'b0;
	logic term_condition = 1'b0;
	logic soc_below_fc_clear = 1'b1;
	logic [4:0] display_segment;
	logic charge_switch_ctl, discharge_switch_ctl, terminate_charge_alarm, over_temperature_alarm;
	logic terminate_discharge_alarm, fully_charged_flag, low_capacity_alarm;
	logic [3:0] pack_safety_status;
	logic [15:0] charge_current_request;
	// Expected notes, the watcher's strobe and scratch values.
	int n_fail = 0;
	int checks_done = 0;
	int seed = 73;
	int pick;
	logic [63:0] q[$];
	logic [63:0] e;
	logic look = 1'b0;
	logic [15:0] uvl, ovl, cv, t;
	logic cov, cuv, cl, dl;
	logic [15:0] tt[4] = '{16'd2981, 16'd3231, 16'd3331, 16'd3332};
	wire [31:0] obs = {display_segment, charge_switch_ctl, discharge_switch_ctl, pack_safety_status,
		terminate_charge_alarm, over_temperature_alarm, terminate_discharge_alarm, fully_charged_flag,
		low_capacity_alarm, charge_current_request};
	csd_button i_csd_button (.mclk, .press, .bounce, .display_request_n);
	csd_top #(.DISPLAY_REQUEST_N_CYCLES(32'd200), .DEB_CYCLES(32'd10), .BLINK_CYCLES(32'd20)) i_csd_top (.mclk, .srst,
		.display_request_n, .display_reference_select, .five_segment_mode, .remaining_cap, .full_charge_cap,
		.design_cap, .low_capacity_level, .end_voltage_zero_flag, .charge_counter_converter_cal,
		.discharging_status, .pack_voltage, .cell_voltage, .charging_voltage, .overvoltage_margin,
		.measured_current, .requested_charge_current, .overcurrent_margin, .maintenance_current, .temperature,
		.max_charge_temp, .safety_temp_byte, .extra_options, .cell_limit_byte, .fast_charge_term,
		.term_condition, .soc_below_fc_clear, .display_segment, .charge_switch_ctl, .discharge_switch_ctl,
		.pack_safety_status, .charge_current_request, .terminate_charge_alarm, .over_temperature_alarm,
		.terminate_discharge_alarm, .fully_charged_flag, .low_capacity_alarm);
	always #25 mclk = ~mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	// Notes a masked expectation and strobes the watcher for one cycle.
	task automatic note(input logic [31:0] m, input logic [31:0] v);
		q.push_back({m, v});
		look = 1'b1;
		tick(1);
		look = 1'b0;
	endtask : note
	// The watcher compares settled outputs with the oldest note.
	always @(negedge mclk) begin
		if (look) begin
			e = q.pop_front();
			check(obs & e[63:32], e[31:0]);
		end
	end
	// Bar pattern worked out from the capacity ratio.
	function automatic logic [4:0] bar(input logic [15:0] r, input logic [15:0] c, input logic f);
		logic [4:0] s;
		s = 5'h01;
		for (int k = 0; k < 4; k++) s[k + 1] = 32'(r) * 100 >= 32'(c) * (f ? 20 : 25) * (k + 1);
		return s;
	endfunction : bar
	// One press held past expiry, then released.
	task automatic show(input logic [4:0] want, input logic blink);
		press = 1'b1;
		tick(23);
		note(32'hf8010000, {want, 10'h000, blink, 16'h0000});
		tick(19);
		note(32'hf8010000, {blink ? 5'h00 : want, 10'h000, blink, 16'h0000});
		tick(180);
		note(32'hf8010000, {15'h0000, blink, 16'h0000});
		press = 1'b0;
		tick(16);
	endtask : show
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		wrap_up();
	end
	initial begin
		tick(10);
		srst = 1'b0;
		tick(2);
		for (int i = 0; i < 10; i++) begin
			five_segment_mode = i[0];
			display_reference_select = i[1];
			low_capacity_level = i[2] ? 16'hffff : 16'h0000;
			remaining_cap = i >= 8 ? (i[0] ? 16'd80 : 16'd25) : 16'($unsigned($random(seed)) % 230);
			show(bar(remaining_cap, i[1] ? design_cap : full_charge_cap, i[0]), i[2]);
			$display("display case %0d done", i);
		end
		low_capacity_level = 16'h0000;
		press = 1'b1;
		tick(24);
		press = 1'b0;
		tick(16);
		press = 1'b1;
		tick(200);
		note(32'hf8000000, 32'h0);
		press = 1'b0;
		bounce = 1'b1;
		tick(40);
		note(32'hf8000000, 32'h0);
		bounce = 1'b0;
		tick(16);
		press = 1'b1;
		tick(23);
		end_voltage_zero_flag = 1'b1;
		tick(1);
		note(32'hf8000000, 32'h0);
		end_voltage_zero_flag = 1'b0;
		charge_counter_converter_cal = 1'b1;
		tick(1);
		note(32'hf8000000, 32'h0);
		charge_counter_converter_cal = 1'b0;
		tick(1);
		// The bar must be lit again so that the reset below has something to clear.
		note(32'hf8000000, {5'h1f, 27'h0});
		srst = 1'b1;
		tick(1);
		note(32'hf8000000, 32'h0);
		srst = 1'b0;
		press = 1'b0;
		$display("display controls done");
		for (int i = 0; i < 16; i++) begin
			srst = 1'b1;
			tick(1);
			srst = 1'b0;
			cell_limit_byte = 8'($random(seed));
			uvl = `CSD_UV_BASE + 16'(cell_limit_byte[7:4]) * `CSD_UV_STEP;
			ovl = `CSD_OV_BASE + 16'(cell_limit_byte[3:0]) * `CSD_OV_STEP;
			pick = $unsigned($random(seed)) % 4;
			cv = pick == 0 ? uvl - 16'd1 : pick == 1 ? uvl : pick == 2 ? ovl - 16'd1 : ovl;
			cell_voltage = {16'd3700, 16'd3700, 16'd3700, cv};
			t = tt[i[1:0]];
			temperature = t;
			extra_options = {1'b0, i[2], 6'h00};
			discharging_status = i[3];
			tick(1);
			cov = t >= 16'd3231 || cv >= ovl;
			cuv = cv < uvl;
			cl = i[2] ? t > 16'd3331 : (t >= 16'd3331 || (cov && !i[3]));
			dl = cuv && i[3];
			note(32'h07ec0000, {5'h00, !cl, !dl, !dl, !cl, cuv, cov, 1'b0, t >= 16'd3231, cuv, 18'h0});
		end
		$display("protection cases done");
		srst = 1'b1;
		temperature = 16'd2981;
		cell_voltage = {4{16'd3700}};
		tick(1);
		srst = 1'b0;
		overvoltage_margin = 16'($random(seed)) & 16'h03ff;
		pack_voltage = charging_voltage + overvoltage_margin;
		tick(1);
		note(32'h00200000, 32'h00200000);
		pack_voltage = 16'd0;
		discharging_status = 1'b1;
		requested_charge_current = 16'($random(seed)) & 16'h0fff;
		overcurrent_margin = 16'($random(seed)) & 16'h00ff;
		maintenance_current = 16'($random(seed)) & 16'h00ff;
		measured_current = requested_charge_current + overcurrent_margin;
		tick(1);
		note(32'h0010ffff, 32'h00100000);
		measured_current = measured_current - 16'h0001;
		tick(1);
		note(32'h0010ffff, {16'h0000, requested_charge_current});
		discharging_status = 1'b0;
		term_condition = 1'b1;
		soc_below_fc_clear = 1'b0;
		fast_charge_term = 1'b1;
		tick(1);
		fast_charge_term = 1'b0;
		tick(1);
		note(32'h0012ffff, {16'h0012, maintenance_current});
		term_condition = 1'b0;
		tick(1);
		note(32'h0012ffff, {16'h0002, maintenance_current});
		soc_below_fc_clear = 1'b1;
		tick(1);
		note(32'h0012ffff, {16'h0000, requested_charge_current});
		// Over-temperature holds inside the release band and clears at its lower edge.
		temperature = 16'd3231;
		tick(1);
		temperature = 16'd3182;
		tick(1);
		note(32'h00080000, 32'h00080000);
		temperature = 16'd3181;
		tick(1);
		note(32'h00080000, 32'h0);
		$display("charge flag cases done");
		wrap_up();
	end
endmodule : csd_top_bench
